// ### tb.sv
// tb: self-checking bench for timer2_core, registers reached over classic wishbone.
// assumes timer2_pkg is compiled first and a single 100 MHz clock.
`timescale 1ns/10ps
module tb;
  // --------------------------------------------------------------------
  // ports, clock and scoreboard
  // --------------------------------------------------------------------
  logic                          clk_i = 1'b0;
  logic                          rst_i = 1'b1;
  logic                          cyc = 1'b0;
  logic                          stb = 1'b0;
  logic                          we = 1'b0;
  logic [timer2_pkg::ADDR_W-1:0] adr = '0;
  logic [3:0]                    sel = 4'h1;
  logic [31:0]                   wdat = '0;
  logic [31:0]                   rdat;
  logic                          ack;
  logic                          gie = 1'b0;
  timer2_pkg::irq_bits_t         vack = '0;
  timer2_pkg::irq_bits_t         irq;
  logic [1:0]                    wave;
  logic [1:0]                    oe;
  logic                          ext_en;
  logic                          async_sel;
  int                            n_mismatch = 0;
  int                            comparisons = 0;
  logic [15:0]                   expq[$];
  logic [15:0]                   note;
  logic [7:0]                    r;
  logic [7:0]                    regs[9] = '{8'h37, 8'h70, 8'hb0, 8'hb1, 8'hb2, 8'hb3, 8'hb4, 8'hb6, 8'h10};
  logic [1:0]                    om[5] = '{2'b01, 2'b10, 2'b11, 2'b01, 2'b00};
  logic                          wv[5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
  int                            dv[8] = '{0, 1, 8, 32, 64, 128, 256, 1024};

  always #5 clk_i = ~clk_i;

  timer2_core dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .gie_i(gie), .vec_ack_i(vack),
    .irq_req_o(irq), .wave_out_o(wave), .wave_oe_o(oe), .ext_clock_input_en_o(ext_en),
    .async_clock_sel_o(async_sel));

  // --------------------------------------------------------------------
  // tasks
  // --------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : check

  task automatic wrap_up();
    $display("counts: %0d comparisons, %0d mismatches", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : wrap_up

  // entered just after a rising edge, leaves one edge after the ack edge
  task automatic wb(input logic [7:0] idx, input logic w, input logic [7:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= {24'h0, d};
    // a lost ack is ended by the watchdog alone
    do
      @(posedge clk_i);
    while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    wb(idx, 1'b1, d);
  endtask : wr

  // tolerance exists because the free prescaler phase is not visible at the ports
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp, input logic [7:0] tol);
    expq.push_back({tol, exp});
    wb(idx, 1'b0, 8'h00);
  endtask : rd

  // caller waits for a falling edge first, so the argument is taken settled
  task automatic pins(input logic [31:0] seen, input logic [31:0] exp);
    check(seen, exp);
    @(posedge clk_i);
  endtask : pins

  // --------------------------------------------------------------------
  // read monitor and watchdog
  // --------------------------------------------------------------------
  always @(posedge clk_i)
  begin
    if (ack === 1'b1 && we === 1'b0 && expq.size() > 0)
    begin
      note = expq.pop_front();
      if (rdat[31:8] === 24'h0 && rdat[7:0] >= note[7:0] - note[15:8] && rdat[7:0] <= note[7:0] + note[15:8])
        check({24'h0, note[7:0]}, {24'h0, note[7:0]});
      else
        check(rdat, {24'h0, note[7:0]});
    end
  end

  initial
  begin
    #600000;
    n_mismatch++;
    wrap_up();
  end

  // --------------------------------------------------------------------
  // tests
  // --------------------------------------------------------------------
  initial
  begin
    void'($urandom(32'h0daa_d048));
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (int i = 0; i < 9; i++)
      rd(regs[i], 8'h00, 8'h00);
    @(negedge clk_i);
    pins({25'h0, irq, wave, oe}, 32'h0);
    $display("test reset done");
    wr(timer2_pkg::IDX_CONTROL_B, 8'hf8);
    rd(timer2_pkg::IDX_CONTROL_B, 8'h08, 8'h00);
    wr(timer2_pkg::IDX_IRQ_MASK, 8'hff);
    rd(timer2_pkg::IDX_IRQ_MASK, 8'h07, 8'h00);
    wr(timer2_pkg::IDX_ASYNC_STATUS, 8'he0);
    rd(timer2_pkg::IDX_ASYNC_STATUS, 8'h60, 8'h00);
    @(negedge clk_i);
    pins({30'h0, ext_en, async_sel}, 32'h3);
    wr(timer2_pkg::IDX_COMPARE_A, 8'h5a);
    rd(timer2_pkg::IDX_ASYNC_STATUS, 8'h68, 8'h00);
    rd(timer2_pkg::IDX_ASYNC_STATUS, 8'h60, 8'h00);
    wr(timer2_pkg::IDX_ASYNC_STATUS, 8'h00);
    wr(timer2_pkg::IDX_CONTROL_B, 8'h00);
    r = 8'($urandom);
    wr(timer2_pkg::IDX_COUNT, r);
    rd(timer2_pkg::IDX_COUNT, r, 8'h00);
    wr(timer2_pkg::IDX_COMPARE_A, ~r);
    rd(timer2_pkg::IDX_COMPARE_A, ~r, 8'h00);
    $display("test access done");
    // counter written while stopped: its first tick after start must not match
    r = 8'($urandom_range(199));
    wr(timer2_pkg::IDX_COMPARE_A, r);
    wr(timer2_pkg::IDX_COMPARE_B, r + 8'h64);
    wr(timer2_pkg::IDX_IRQ_FLAGS, 8'h07);
    wr(timer2_pkg::IDX_COUNT, r);
    wr(timer2_pkg::IDX_CONTROL_B, 8'h01);
    wr(timer2_pkg::IDX_CONTROL_B, 8'h00);
    rd(timer2_pkg::IDX_IRQ_FLAGS, 8'h00, 8'h00);
    $display("test blocking done");
    wr(timer2_pkg::IDX_COUNT, 8'hfc);
    wr(timer2_pkg::IDX_COMPARE_A, 8'hfe);
    wr(timer2_pkg::IDX_COMPARE_B, 8'h01);
    wr(timer2_pkg::IDX_CONTROL_B, 8'h01);
    repeat (10) @(posedge clk_i);
    wr(timer2_pkg::IDX_CONTROL_B, 8'h00);
    rd(timer2_pkg::IDX_IRQ_FLAGS, 8'h07, 8'h00);
    gie <= 1'b1;
    @(negedge clk_i);
    pins({29'h0, irq}, 32'h7);
    wr(timer2_pkg::IDX_IRQ_MASK, 8'h05);
    @(negedge clk_i);
    pins({29'h0, irq}, 32'h5);
    gie <= 1'b0;
    @(negedge clk_i);
    pins({29'h0, irq}, 32'h0);
    wr(timer2_pkg::IDX_IRQ_FLAGS, 8'h01);
    rd(timer2_pkg::IDX_IRQ_FLAGS, 8'h06, 8'h00);
    vack <= 3'b100;
    @(posedge clk_i);
    vack <= 3'b000;
    @(posedge clk_i);
    rd(timer2_pkg::IDX_IRQ_FLAGS, 8'h02, 8'h00);
    wr(timer2_pkg::IDX_IRQ_FLAGS, 8'h02);
    $display("test flags done");
    // clear-on-match mode with the counter sitting on compare a
    wr(timer2_pkg::IDX_COUNT, 8'h55);
    wr(timer2_pkg::IDX_COMPARE_A, 8'h55);
    for (int i = 0; i < 5; i++)
    begin
      wr(timer2_pkg::IDX_CONTROL_A, {om[i], om[i], 4'h2});
      wr(timer2_pkg::IDX_CONTROL_B, 8'hc0);
      @(negedge clk_i);
      pins({30'h0, wave}, {30'h0, wv[i], wv[i]});
    end
    rd(timer2_pkg::IDX_IRQ_FLAGS, 8'h00, 8'h00);
    rd(timer2_pkg::IDX_COUNT, 8'h55, 8'h00);
    // fast pwm: a force strobe must leave the pin alone, channel b toggle drops its enable
    wr(timer2_pkg::IDX_CONTROL_A, 8'hd3);
    wr(timer2_pkg::IDX_CONTROL_B, 8'h80);
    @(negedge clk_i);
    pins({28'h0, wave, oe}, 32'h1);
    wr(timer2_pkg::IDX_CONTROL_B, 8'h00);
    wr(timer2_pkg::IDX_CONTROL_A, 8'h00);
    $display("test force done");
    for (int c = 0; c < 8; c++)
    begin
      wr(timer2_pkg::IDX_COUNT, 8'h00);
      wr(timer2_pkg::IDX_CONTROL_B, 8'(c));
      repeat (16 * dv[c]) @(posedge clk_i);
      rd(timer2_pkg::IDX_COUNT, (c == 0) ? 8'h00 : 8'h10, 8'h02);
      wr(timer2_pkg::IDX_CONTROL_B, 8'h00);
    end
    $display("test prescaler done");
    wrap_up();
  end
endmodule : tb

// ### timer2_core.sv
// timer2_core: 8-bit timer/counter with two compare channels, flags,
// mask and update-busy status, reached over classic Wishbone.
// assumes clk_i feeds the prescaler, vector acknowledges and the global
// interrupt enable come from the cpu on the same clock.
//
// The Wishbone slave port is this design's own decision.
`timescale 1ns/10ps
module timer2_core (
  // clock and reset
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  // wishbone slave
  input  wire logic                          cyc_i,
  input  wire logic                          stb_i,
  input  wire logic                          we_i,
  input  wire logic [timer2_pkg::ADDR_W-1:0] adr_i,
  input  wire logic [3:0]                    sel_i,
  input  wire logic [31:0]                   dat_i,
  output logic      [31:0]                   dat_o,
  output logic                               ack_o,
  // cpu interrupt side
  input  wire logic                          gie_i,
  input  timer2_pkg::irq_bits_t              vec_ack_i,
  output timer2_pkg::irq_bits_t              irq_req_o,
  // waveform pins, bit 0 channel a, bit 1 channel b
  output logic      [1:0]                    wave_out_o,
  output logic      [1:0]                    wave_oe_o,
  // oscillator control
  output logic                               ext_clock_input_en_o,
  output logic                               async_clock_sel_o
);

  // ----------------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------------
  logic        ack_q;
  logic [31:0] dat_q;
  logic [7:0]  rd_byte;
  logic [7:0]  idx;
  logic        req;
  logic        wr_en;
  logic [7:0]  wdat;

  assign req   = cyc_i & stb_i;
  assign idx   = adr_i[timer2_pkg::ADDR_W-1:2];
  // writes land on the edge that samples ack, once per request with sel_i[0] set
  assign wr_en = req & we_i & ack_q & sel_i[0];
  assign wdat  = dat_i[7:0];
  assign ack_o = ack_q;
  assign dat_o = dat_q;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_q <= 1'b0;
    else
      ack_q <= req & ~ack_q;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      dat_q <= 32'h0000_0000;
    else if (req & ~ack_q & ~we_i)
      dat_q <= {24'h00_0000, rd_byte};
  end

  logic wr_flags, wr_mask, wr_ctla, wr_ctlb, wr_cnt, wr_ocra, wr_ocrb, wr_async;
  assign wr_flags = wr_en & (idx == timer2_pkg::IDX_IRQ_FLAGS);
  assign wr_mask  = wr_en & (idx == timer2_pkg::IDX_IRQ_MASK);
  assign wr_ctla  = wr_en & (idx == timer2_pkg::IDX_CONTROL_A);
  assign wr_ctlb  = wr_en & (idx == timer2_pkg::IDX_CONTROL_B);
  assign wr_cnt   = wr_en & (idx == timer2_pkg::IDX_COUNT);
  assign wr_ocra  = wr_en & (idx == timer2_pkg::IDX_COMPARE_A);
  assign wr_ocrb  = wr_en & (idx == timer2_pkg::IDX_COMPARE_B);
  assign wr_async = wr_en & (idx == timer2_pkg::IDX_ASYNC_STATUS);

  // ----------------------------------------------------------------------
  // control and configuration registers
  // ----------------------------------------------------------------------
  timer2_pkg::out_mode_t  out_mode_a_q, out_mode_b_q;
  logic [1:0]             wave_mode_lo_q;
  logic                   wave_mode_hi_q;
  timer2_pkg::clk_sel_t   clock_select_field_q;
  logic [7:0]             ocr_q [2];
  timer2_pkg::irq_bits_t  mask_q;
  logic                   ext_clk_q, async_sel_q;
  timer2_pkg::wave_mode_t mode;
  logic                   pwm;

  assign mode = timer2_pkg::wave_mode_t'({wave_mode_hi_q, wave_mode_lo_q});
  assign pwm  = wave_mode_lo_q[0];

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      out_mode_a_q   <= timer2_pkg::OM_OFF;
      out_mode_b_q   <= timer2_pkg::OM_OFF;
      wave_mode_lo_q <= 2'b00;
    end
    else if (wr_ctla)
    begin
      out_mode_a_q   <= timer2_pkg::out_mode_t'(wdat[timer2_pkg::CTLA_OUT_A_LSB +: 2]);
      out_mode_b_q   <= timer2_pkg::out_mode_t'(wdat[timer2_pkg::CTLA_OUT_B_LSB +: 2]);
      wave_mode_lo_q <= wdat[timer2_pkg::CTLA_WAVE_LO_LSB +: 2];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wave_mode_hi_q       <= 1'b0;
      clock_select_field_q <= timer2_pkg::CS_STOP;
    end
    else if (wr_ctlb)
    begin
      wave_mode_hi_q       <= wdat[timer2_pkg::CTLB_WAVE_HI_BIT];
      clock_select_field_q <= timer2_pkg::clk_sel_t'(wdat[timer2_pkg::CTLB_CS_LSB +: 3]);
    end
  end

  // compare registers take effect at once in every mode
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ocr_q[0] <= timer2_pkg::RST_BYTE;
      ocr_q[1] <= timer2_pkg::RST_BYTE;
    end
    else
    begin
      if (wr_ocra)
        ocr_q[0] <= wdat;
      if (wr_ocrb)
        ocr_q[1] <= wdat;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      mask_q <= timer2_pkg::irq_bits_t'(3'b000);
    else if (wr_mask)
      mask_q <= timer2_pkg::irq_bits_t'(wdat[2:0]);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ext_clk_q   <= 1'b0;
      async_sel_q <= 1'b0;
    end
    else if (wr_async)
    begin
      ext_clk_q   <= wdat[timer2_pkg::ASYNC_EXT_BIT];
      async_sel_q <= wdat[timer2_pkg::ASYNC_SEL_BIT];
    end
  end

  assign ext_clock_input_en_o = ext_clk_q;
  assign async_clock_sel_o    = async_sel_q;

  // ----------------------------------------------------------------------
  // prescaler and timer tick
  // ----------------------------------------------------------------------
  logic [timer2_pkg::PRE_W-1:0] pre_q;
  logic                         tick;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pre_q <= '0;
    else
      pre_q <= pre_q + 1'b1;
  end

  always_comb
  begin
    case (clock_select_field_q)
      timer2_pkg::CS_STOP:    tick = 1'b0;
      timer2_pkg::CS_DIV1:    tick = 1'b1;
      timer2_pkg::CS_DIV8:    tick = &pre_q[2:0];
      timer2_pkg::CS_DIV32:   tick = &pre_q[4:0];
      timer2_pkg::CS_DIV64:   tick = &pre_q[5:0];
      timer2_pkg::CS_DIV128:  tick = &pre_q[6:0];
      timer2_pkg::CS_DIV256:  tick = &pre_q[7:0];
      timer2_pkg::CS_DIV1024: tick = &pre_q[9:0];
      default:                tick = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------------
  logic [7:0] cnt_q;
  logic       down_q;
  logic       block_q;
  logic [7:0] top;
  logic       at_top;
  logic       is_fast, is_pc;
  logic       wrap_ev;
  logic       ovf_ev;

  assign top     = wave_mode_hi_q | (mode == timer2_pkg::WM_CTC) ? ocr_q[0] : timer2_pkg::COUNT_MAX;
  assign at_top  = (cnt_q == top);
  assign is_fast = (mode == timer2_pkg::WM_FAST_MAX) | (mode == timer2_pkg::WM_FAST_CMPA);
  assign is_pc   = (mode == timer2_pkg::WM_PC_MAX) | (mode == timer2_pkg::WM_PC_CMPA);
  assign wrap_ev = tick & ~wr_cnt & is_fast & at_top;

  always_comb
  begin
    if (is_pc)
      ovf_ev = tick & ~wr_cnt & down_q & (cnt_q == timer2_pkg::COUNT_BOTTOM);
    else if (is_fast)
      ovf_ev = wrap_ev;
    else
      ovf_ev = tick & ~wr_cnt & (cnt_q == timer2_pkg::COUNT_MAX);
  end

  // software write wins over a tick in the same cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_q  <= timer2_pkg::RST_BYTE;
      down_q <= 1'b0;
    end
    else if (wr_cnt)
      cnt_q <= wdat;
    else if (tick)
    begin
      if (is_pc)
      begin
        if (!down_q && at_top)
        begin
          down_q <= 1'b1;
          cnt_q  <= cnt_q - 1'b1;
        end
        else if (down_q && cnt_q == timer2_pkg::COUNT_BOTTOM)
        begin
          down_q <= 1'b0;
          cnt_q  <= cnt_q + 1'b1;
        end
        else
          cnt_q <= down_q ? cnt_q - 1'b1 : cnt_q + 1'b1;
      end
      else if ((is_fast || mode == timer2_pkg::WM_CTC) && at_top)
        cnt_q <= timer2_pkg::COUNT_BOTTOM;
      else
      begin
        down_q <= 1'b0;
        cnt_q  <= cnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      block_q <= 1'b0;
    else if (wr_cnt)
      block_q <= 1'b1;
    else if (tick)
      block_q <= 1'b0;
  end

  // ----------------------------------------------------------------------
  // compare channels and waveform outputs
  // ----------------------------------------------------------------------
  logic [1:0] match_ev;
  logic [1:0] force_ev;
  logic [1:0] wave_vec;
  logic [1:0] force_bits;

  assign force_bits = {wdat[timer2_pkg::CTLB_FORCE_B_BIT], wdat[timer2_pkg::CTLB_FORCE_A_BIT]};

  for (genvar ch = 0; ch < 2; ch++)
  begin : g_chan
    timer2_pkg::out_mode_t om;
    logic                  wave_q;
    logic                  wave_d;
    logic                  match_ignored;

    assign om = (ch == 0) ? out_mode_a_q : out_mode_b_q;
    assign match_ev[ch] = tick & ~wr_cnt & ~block_q & (cnt_q == ocr_q[ch]);
    // mode bits are taken before the write lands, so a strobe in a pwm write is dropped
    assign force_ev[ch] = wr_ctlb & force_bits[ch] & ~pwm;
    assign match_ignored = om[1] & (ocr_q[ch] == top);

    always_comb
    begin
      wave_d = wave_q;
      if (force_ev[ch] || (!pwm && match_ev[ch]))
      begin
        case (om)
          timer2_pkg::OM_TOGGLE: wave_d = ~wave_q;
          timer2_pkg::OM_CLEAR:  wave_d = 1'b0;
          timer2_pkg::OM_SET:    wave_d = 1'b1;
          default:               wave_d = wave_q;
        endcase
      end
      else if (pwm && match_ev[ch] && !(is_fast && match_ignored))
      begin
        case (om)
          timer2_pkg::OM_TOGGLE: wave_d = (ch == 0 && wave_mode_hi_q) ? ~wave_q : wave_q;
          timer2_pkg::OM_CLEAR:  wave_d = is_fast ? 1'b0 : down_q;
          timer2_pkg::OM_SET:    wave_d = is_fast ? 1'b1 : ~down_q;
          default:               wave_d = wave_q;
        endcase
      end
      if (wrap_ev && om[1])
        wave_d = ~om[0];
    end

    always_ff @(posedge clk_i)
    begin
      if (rst_i)
        wave_q <= 1'b0;
      else
        wave_q <= wave_d;
    end

    assign wave_vec[ch]   = wave_q;
    assign wave_oe_o[ch]  = (om != timer2_pkg::OM_OFF) & ~(ch == 1 && pwm && om == timer2_pkg::OM_TOGGLE);
  end

  assign wave_out_o = wave_vec;

  // ----------------------------------------------------------------------
  // interrupt flags and requests
  // ----------------------------------------------------------------------
  timer2_pkg::irq_bits_t flags_q;
  timer2_pkg::irq_bits_t flag_set;
  timer2_pkg::irq_bits_t flag_clr;

  // forced strobes never reach the flags
  assign flag_set = timer2_pkg::irq_bits_t'({match_ev[1], match_ev[0], ovf_ev});
  assign flag_clr = timer2_pkg::irq_bits_t'((wr_flags ? wdat[2:0] : 3'b000) | vec_ack_i);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      flags_q <= timer2_pkg::irq_bits_t'(3'b000);
    else
      flags_q <= (flags_q & ~flag_clr) | flag_set;
  end

  assign irq_req_o = flags_q & mask_q & {3{gie_i}};

  // ----------------------------------------------------------------------
  // update-busy status
  // ----------------------------------------------------------------------
  logic [4:0] busy_q;
  logic [4:0] busy_set;
  logic [3:0] upd_cnt_q;

  assign busy_set = {wr_cnt, wr_ocra, wr_ocrb, wr_ctla, wr_ctlb} & {5{async_sel_q}};

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      upd_cnt_q <= 4'h0;
    else if (|busy_set)
      upd_cnt_q <= timer2_pkg::UPDATE_CYCLES;
    else if (upd_cnt_q != 4'h0)
      upd_cnt_q <= upd_cnt_q - 4'h1;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      busy_q <= 5'h00;
    else
      busy_q <= ((upd_cnt_q == 4'h1) ? 5'h00 : busy_q) | busy_set;
  end

  // ----------------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------------
  always_comb
  begin
    case (idx)
      timer2_pkg::IDX_IRQ_FLAGS:    rd_byte = {5'h00, flags_q};
      timer2_pkg::IDX_IRQ_MASK:     rd_byte = {5'h00, mask_q};
      timer2_pkg::IDX_CONTROL_A:    rd_byte = {out_mode_a_q, out_mode_b_q, 2'b00, wave_mode_lo_q};
      timer2_pkg::IDX_CONTROL_B:    rd_byte = {4'h0, wave_mode_hi_q, clock_select_field_q};
      timer2_pkg::IDX_COUNT:        rd_byte = cnt_q;
      timer2_pkg::IDX_COMPARE_A:    rd_byte = ocr_q[0];
      timer2_pkg::IDX_COMPARE_B:    rd_byte = ocr_q[1];
      timer2_pkg::IDX_ASYNC_STATUS: rd_byte = {1'b0, ext_clk_q, async_sel_q, busy_q};
      default:                      rd_byte = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_ctlb_read;
    req & ~we_i & ~ack_q & (idx == timer2_pkg::IDX_CONTROL_B);
  endsequence
  property p_force_reads_zero;
    s_ctlb_read |=> ack_o && dat_o[7:4] == 4'h0;
  endproperty
  a_force_reads_zero: assert property (p_force_reads_zero) else $error("control b force bits read nonzero");

  sequence s_count_written;
    wr_cnt ##1 (!tick && !wr_cnt) [*2];
  endsequence
  property p_block_after_write;
    s_count_written |-> block_q && match_ev == 2'b00;
  endproperty
  a_block_after_write: assert property (p_block_after_write) else $error("match not blocked after count write");

  property p_blocked_tick;
    (block_q && tick && !wr_cnt) |-> match_ev == 2'b00 ##1 !block_q;
  endproperty
  a_blocked_tick: assert property (p_blocked_tick) else $error("blocked tick produced a match");

  property p_force_no_flag;
    (wr_ctlb && force_bits[0] && !match_ev[0]) |=> !$rose(flags_q.match_a);
  endproperty
  a_force_no_flag: assert property (p_force_no_flag) else $error("force strobe set a flag");

  property p_pwm_force_ignored;
    (wr_ctlb && force_bits[0] && pwm && !match_ev[0] && !wrap_ev) |=> $stable(wave_out_o[0]);
  endproperty
  a_pwm_force_ignored: assert property (p_pwm_force_ignored) else $error("force acted in pwm mode");

  property p_w1c_clears;
    (wr_flags && wdat[0] && !ovf_ev) |=> !flags_q.overflow;
  endproperty
  a_w1c_clears: assert property (p_w1c_clears) else $error("write one did not clear flag");

  property p_w0_keeps;
    (wr_flags && !wdat[1] && flags_q.match_a && !vec_ack_i.match_a) |=> flags_q.match_a;
  endproperty
  a_w0_keeps: assert property (p_w0_keeps) else $error("write zero cleared flag");

  property p_vec_clears;
    (vec_ack_i.match_b && !match_ev[1]) |=> !flags_q.match_b;
  endproperty
  a_vec_clears: assert property (p_vec_clears) else $error("vector ack did not clear flag");

  property p_ovf_sets;
    ovf_ev |=> flags_q.overflow;
  endproperty
  a_ovf_sets: assert property (p_ovf_sets) else $error("overflow flag not set");

  property p_irq_gate;
    irq_req_o.overflow |-> flags_q.overflow && mask_q.overflow && gie_i;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("request without mask flag and enable");

  property p_stopped;
    (clock_select_field_q == timer2_pkg::CS_STOP && !wr_cnt) |=> $stable(cnt_q);
  endproperty
  a_stopped: assert property (p_stopped) else $error("counter moved while stopped");

  property p_busy_set;
    (async_sel_q && wr_ocra) |=> busy_q[3] ##1 busy_q[3] ##1 (!busy_q[3] || $past(busy_set) != 5'h00);
  endproperty
  a_busy_set: assert property (p_busy_set) else $error("update busy timing wrong");

endmodule : timer2_core

// ### timer2_pkg.sv
// timer2_pkg: register indices, field positions, reset values, encodings
// and timing constants of the 8-bit timer with two compare channels.
// assumes a 32-bit classic Wishbone bus; each register sits at 4 * index.
package timer2_pkg;

  // ----------------------------------------------------------------------
  // register indices (byte address = 4 * index)
  // ----------------------------------------------------------------------
  localparam int unsigned ADDR_W           = 10;
  localparam logic [7:0]  IDX_IRQ_FLAGS    = 8'h37;
  localparam logic [7:0]  IDX_IRQ_MASK     = 8'h70;
  localparam logic [7:0]  IDX_CONTROL_A    = 8'hb0;
  localparam logic [7:0]  IDX_CONTROL_B    = 8'hb1;
  localparam logic [7:0]  IDX_COUNT        = 8'hb2;
  localparam logic [7:0]  IDX_COMPARE_A    = 8'hb3;
  localparam logic [7:0]  IDX_COMPARE_B    = 8'hb4;
  localparam logic [7:0]  IDX_ASYNC_STATUS = 8'hb6;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int unsigned CTLB_FORCE_A_BIT = 7;
  localparam int unsigned CTLB_FORCE_B_BIT = 6;
  localparam int unsigned CTLB_WAVE_HI_BIT = 3;
  localparam int unsigned CTLB_CS_LSB      = 0;
  localparam int unsigned CTLA_OUT_A_LSB   = 6;
  localparam int unsigned CTLA_OUT_B_LSB   = 4;
  localparam int unsigned CTLA_WAVE_LO_LSB = 0;
  localparam int unsigned ASYNC_EXT_BIT    = 6;
  localparam int unsigned ASYNC_SEL_BIT    = 5;
  localparam int unsigned ASYNC_BUSY_LSB   = 0;

  // ----------------------------------------------------------------------
  // reset values and counter landmarks
  // ----------------------------------------------------------------------
  localparam logic [7:0]  RST_BYTE         = 8'h00;
  localparam logic [7:0]  COUNT_MAX        = 8'hff;
  localparam logic [7:0]  COUNT_BOTTOM     = 8'h00;

  // ----------------------------------------------------------------------
  // timing: prescaler width and busy hold after an async-mode write
  // ----------------------------------------------------------------------
  localparam int unsigned PRE_W            = 10;
  localparam logic [3:0]  UPDATE_CYCLES    = 4'h2;

  // ----------------------------------------------------------------------
  // encodings and carriers
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    CS_STOP    = 3'b000,
    CS_DIV1    = 3'b001,
    CS_DIV8    = 3'b010,
    CS_DIV32   = 3'b011,
    CS_DIV64   = 3'b100,
    CS_DIV128  = 3'b101,
    CS_DIV256  = 3'b110,
    CS_DIV1024 = 3'b111
  } clk_sel_t;

  typedef enum logic [2:0] {
    WM_NORMAL    = 3'b000,
    WM_PC_MAX    = 3'b001,
    WM_CTC       = 3'b010,
    WM_FAST_MAX  = 3'b011,
    WM_RSVD_4    = 3'b100,
    WM_PC_CMPA   = 3'b101,
    WM_RSVD_6    = 3'b110,
    WM_FAST_CMPA = 3'b111
  } wave_mode_t;

  typedef enum logic [1:0] {
    OM_OFF    = 2'b00,
    OM_TOGGLE = 2'b01,
    OM_CLEAR  = 2'b10,
    OM_SET    = 2'b11
  } out_mode_t;

  typedef struct packed {
    logic match_b;
    logic match_a;
    logic overflow;
  } irq_bits_t;

endpackage : timer2_pkg
